// File: src/frvc_fifo.sv
// Dual-clock FIFO with gray-coded pointers for read data bytes.
`timescale 1ns/100ps
`default_nettype none

module frvc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // Write side
   input  wire logic         wclk,
   input  wire logic         wrst,
   input  wire logic         w_valid,
   output logic              w_ready,
   input  wire logic [W-1:0] w_data,
   // Read side
   input  wire logic         rclk,
   input  wire logic         rrst,
   output logic              r_valid,
   input  wire logic         r_ready,
   output logic [W-1:0]      r_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin_reg;
   logic [AW:0]  wgray_reg;
   logic [AW:0]  rbin_reg;
   logic [AW:0]  rgray_reg;
   logic [AW:0]  rgray_w;
   logic [AW:0]  wgray_r;
   logic [AW:0]  wbin_next;
   logic [AW:0]  rbin_next;
   logic         push;
   logic         pop;

   assign wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
   assign rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};
   assign w_ready   = (wgray_reg != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
   assign r_valid   = (rgray_reg != wgray_r);
   assign push      = w_valid && w_ready;
   assign pop       = r_valid && r_ready;
   assign r_data    = mem[rbin_reg[AW-1:0]];

   always_ff @(posedge wclk) begin
      if (push) begin
         mem[wbin_reg[AW-1:0]] <= w_data;
      end
   end

   always_ff @(posedge wclk) begin
      if (wrst) begin
         wbin_reg  <= '0;
         wgray_reg <= '0;
      end else if (push) begin
         wbin_reg  <= wbin_next;
         wgray_reg <= wbin_next ^ (wbin_next >> 1);
      end
   end

   // The read side is cleared by the frame's own end, so no edge is needed.
   always_ff @(posedge rclk or posedge rrst) begin
      if (rrst) begin
         rbin_reg  <= '0;
         rgray_reg <= '0;
      end else if (pop) begin
         rbin_reg  <= rbin_next;
         rgray_reg <= rbin_next ^ (rbin_next >> 1);
      end
   end

   frvc_sync #(.W(AW+1)) u_rptr_sync (
      .clk  (wclk),
      .srst (wrst),
      .arst (1'b0),
      .d    (rgray_reg),
      .q    (rgray_w)
   );

   frvc_sync #(.W(AW+1)) u_wptr_sync (
      .clk  (rclk),
      .srst (1'b0),
      .arst (rrst),
      .d    (wgray_reg),
      .q    (wgray_r)
   );

endmodule : frvc_fifo

`default_nettype wire

// File: src/frvc_pkg.sv
// Package of constants, types and helpers for the read configuration block.
package frvc_pkg;

   // ----------------------------------------------------------------------
   // Register layout
   // ----------------------------------------------------------------------
   localparam logic [7:0] VCR_RESET = 8'hfb;
   localparam logic [7:0] VCR_WMASK = 8'hfb;
   localparam int         DUMMY_MSB = 7;
   localparam int         DUMMY_LSB = 4;
   localparam int         XIP_BIT   = 3;
   localparam int         WRAP_MSB  = 1;
   localparam int         WRAP_LSB  = 0;

   // ----------------------------------------------------------------------
   // Field codes
   // ----------------------------------------------------------------------
   localparam logic [3:0] DUMMY_CODE_LO = 4'h0;
   localparam logic [3:0] DUMMY_CODE_HI = 4'hf;
   localparam logic [3:0] DUMMY_DFLT    = 4'ha;
   localparam logic [1:0] WRAP_16       = 2'h0;
   localparam logic [1:0] WRAP_32       = 2'h1;
   localparam logic [1:0] WRAP_64       = 2'h2;
   localparam logic [1:0] WRAP_SEQ      = 2'h3;
   localparam logic [3:0] FEAT_XIP_A    = 4'h2;
   localparam logic [3:0] FEAT_XIP_B    = 4'h4;
   localparam logic [1:0] PROTO_EXT     = 2'h0;
   localparam logic [1:0] PROTO_DUAL    = 2'h1;
   localparam logic [1:0] PROTO_QUAD    = 2'h2;

   // ----------------------------------------------------------------------
   // Serial commands and sizes
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_FAST_READ = 8'h0b;
   localparam logic [7:0] CMD_WR_VCR    = 8'h81;
   localparam logic [7:0] CMD_RD_VCR    = 8'h85;
   localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
   localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
   localparam logic [7:0] EMPTY_BYTE    = 8'hff;
   localparam logic [1:0] STRAP_WAIT    = 2'h3;
   localparam int         MEM_AW        = 8;
   localparam int         FIFO_W        = 8;
   localparam int         FIFO_DEPTH    = 4;

   // ----------------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      LK_START  = 3'h0,
      LK_CMD    = 3'h1,
      LK_ADDR   = 3'h2,
      LK_DUMMY  = 3'h3,
      LK_DATA   = 3'h4,
      LK_WCFG   = 3'h5,
      LK_IGNORE = 3'h6
   } frvc_link_t;

   typedef enum logic {
      FT_IDLE = 1'b0,
      FT_RUN  = 1'b1
   } frvc_fetch_t;

   // Next byte address: wrap inside the aligned block or run on.
   function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                             input logic [1:0]  w);
      logic [23:0] m;
      logic [23:0] inc;
      m   = 24'h00000f;
      inc = a + 24'h000001;
      case (w)
         WRAP_16: m = 24'h00000f;
         WRAP_32: m = 24'h00001f;
         WRAP_64: m = 24'h00003f;
         default: m = 24'hffffff;
      endcase
      wrap_next = (a & ~m) | (inc & m);
   endfunction : wrap_next

endpackage : frvc_pkg

// File: src/frvc_sync.sv
// Two flip-flop synchroniser for levels and gray-coded words.
`timescale 1ns/100ps
`default_nettype none

module frvc_sync #(
   parameter int W = 1
) (
   // Clock and resets
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         arst,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or posedge arst) begin
      if (arst) begin
         meta_reg <= '0;
         q        <= '0;
      end else if (srst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : frvc_sync

`default_nettype wire

// File: src/frvc_top.sv
// Volatile read configuration register and serial read path of the flash.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [R1] Bits 7:4 give the dummy cycles inserted after the address of a read.
// [R2] Dummy codes 0000 and 1111 both select the default dummy count.
// [R3] Dummy codes 0001 to 1110 are the plain binary dummy count.
// [R4] The host must program enough dummy cycles or it reads wrong data.
// [R5] The host must keep the serial clock under the limit for its count.
// [R6] Bit 3 low enables execute-in-place, high disables it by default.
// [R7] On feature digit 2 or 4 the device is always in execute-in-place.
// [R8] Bit 2 is reserved and always reads as zero.
// [R9] Wrap code 00 wraps output within the aligned 16-byte block.
// [R10] Wrap codes 01 and 10 wrap within aligned 32 and 64 byte blocks.
// [R11] Wrap code 11 is the default and reads on sequentially.
// [R12] Wrapped bytes follow the aligned block order from the start byte.
// [R13] A register write takes effect by the write command; a read returns it.
// [R14] Protocol straps low select dual or quad I/O from the next power-on.
// [R15] Reset returns all volatile bits to their defaults.
module frvc_top #(
   parameter logic [3:0] FEATURE_DIGIT = 4'h1
) (
   // Core clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // Serial link
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output logic            so,
   output logic            so_oe,
   // Nonvolatile protocol straps
   input  wire logic       nv_dual_n,
   input  wire logic       nv_quad_n,
   // Array load port
   input  wire logic       mem_we,
   input  wire logic [7:0] mem_addr,
   input  wire logic [7:0] mem_wdata,
   // Status
   output logic            xip_active,
   output logic [1:0]      io_protocol,
   output logic [7:0]      cfg_value
);

   // ----------------------------------------------------------------------
   // Core domain: register, array, fetch
   // ----------------------------------------------------------------------
   logic [7:0]   mem [2**frvc_pkg::MEM_AW];
   logic [7:0]   vcr_reg;
   logic         lrst_reg;
   logic         rtog_d_reg;
   logic         ctog_d_reg;
   logic [23:0]  fetch_addr_reg;
   logic [1:0]   fetch_wrap_reg;
   logic [1:0]   strap_cnt_reg;
   frvc_pkg::frvc_fetch_t fetch_reg;
   logic [4:0]   core_sync_in;
   logic [4:0]   core_sync_q;
   logic         rtog_s;
   logic         ctog_s;
   logic         cs_hi_s;
   logic         dual_n_s;
   logic         quad_n_s;
   logic         req_seen;
   logic         cfg_seen;
   logic         fifo_wrst;
   logic         fifo_wvalid;
   logic         fifo_wready;
   logic         feat_xip;
   logic [1:0]   proto_sel;

   // Link domain signals read by the core side.
   logic         req_tog_reg;
   logic         cfg_tog_reg;
   logic [23:0]  req_addr_reg;
   logic [7:0]   cfg_wdata_reg;

   assign core_sync_in = {req_tog_reg, cfg_tog_reg, cs_n, nv_dual_n,
                          nv_quad_n};
   assign {rtog_s, ctog_s, cs_hi_s, dual_n_s, quad_n_s} = core_sync_q;
   assign req_seen    = rtog_s ^ rtog_d_reg;
   assign cfg_seen    = ctog_s ^ ctog_d_reg;
   assign fifo_wrst   = srst || cs_hi_s;
   assign fifo_wvalid = (fetch_reg == frvc_pkg::FT_RUN) && !cs_hi_s;
   assign feat_xip    = (FEATURE_DIGIT == frvc_pkg::FEAT_XIP_A) ||
                        (FEATURE_DIGIT == frvc_pkg::FEAT_XIP_B);
   assign proto_sel   = !quad_n_s ? frvc_pkg::PROTO_QUAD :       // [R14]
                        !dual_n_s ? frvc_pkg::PROTO_DUAL :
                                    frvc_pkg::PROTO_EXT;

   frvc_sync #(.W(5)) u_core_sync (
      .clk  (core_clk),
      .srst (srst),
      .arst (1'b0),
      .d    (core_sync_in),
      .q    (core_sync_q)
   );

   always_ff @(posedge core_clk) begin
      lrst_reg <= srst;
   end

   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end

   // The register changes only when a write command has completed.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         vcr_reg    <= frvc_pkg::VCR_RESET;                      // [R15]
         ctog_d_reg <= 1'b0;
      end else begin
         ctog_d_reg <= ctog_s;
         if (cfg_seen) begin
            vcr_reg <= cfg_wdata_reg & frvc_pkg::VCR_WMASK;      // [R13] [R8]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         xip_active <= 1'b0;
         cfg_value  <= frvc_pkg::VCR_RESET;
      end else begin
         xip_active <= feat_xip || !vcr_reg[frvc_pkg::XIP_BIT];  // [R6] [R7]
         cfg_value  <= vcr_reg;
      end
   end

   // Straps are caught once, after the synchronisers have settled.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         strap_cnt_reg <= 2'h0;
         io_protocol   <= frvc_pkg::PROTO_EXT;
      end else if (strap_cnt_reg != frvc_pkg::STRAP_WAIT) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == frvc_pkg::STRAP_WAIT - 2'h1) begin
            io_protocol <= proto_sel;                            // [R14]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fetch_reg      <= frvc_pkg::FT_IDLE;
         rtog_d_reg     <= 1'b0;
         fetch_addr_reg <= 24'h000000;
         fetch_wrap_reg <= frvc_pkg::WRAP_SEQ;
      end else begin
         rtog_d_reg <= rtog_s;
         if (req_seen) begin
            fetch_reg      <= frvc_pkg::FT_RUN;
            fetch_addr_reg <= req_addr_reg;
            fetch_wrap_reg <= vcr_reg[frvc_pkg::WRAP_MSB:frvc_pkg::WRAP_LSB];
         end else if (cs_hi_s) begin
            fetch_reg <= frvc_pkg::FT_IDLE;
         end else if (fifo_wvalid && fifo_wready) begin
            fetch_addr_reg <= frvc_pkg::wrap_next(fetch_addr_reg,
                                 fetch_wrap_reg);  // [R9] [R10] [R11] [R12]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Crossing buffer
   // ----------------------------------------------------------------------
   logic         fifo_rvalid;
   logic         fifo_rready;
   logic [7:0]   fifo_rdata;

   frvc_fifo #(.W(frvc_pkg::FIFO_W), .DEPTH(frvc_pkg::FIFO_DEPTH)) u_fifo (
      .wclk    (core_clk),
      .wrst    (fifo_wrst),
      .w_valid (fifo_wvalid),
      .w_ready (fifo_wready),
      .w_data  (mem[fetch_addr_reg[frvc_pkg::MEM_AW-1:0]]),
      .rclk    (sclk),
      .rrst    (cs_n),
      .r_valid (fifo_rvalid),
      .r_ready (fifo_rready),
      .r_data  (fifo_rdata)
   );

   // ----------------------------------------------------------------------
   // Link domain: command decode, dummy count, shift out
   // ----------------------------------------------------------------------
   frvc_pkg::frvc_link_t state_reg;
   logic [4:0]   bit_cnt_reg;
   logic [23:0]  sh_reg;
   logic [3:0]   dcnt_reg;
   logic         dfirst_reg;
   logic [7:0]   out_sr_reg;
   logic         rd_cfg_reg;
   logic         xip_hold_reg;
   logic [7:0]   vcr_s;
   logic [23:0]  sh_next;
   logic [3:0]   dummy_code;
   logic [3:0]   dummy_num;
   logic         xip_en;
   logic         byte_end;
   logic         req_fire;
   logic         cfg_fire;
   logic         dummy_end;
   logic [7:0]   pop_byte;

   frvc_sync #(.W(8)) u_cfg_sync (
      .clk  (sclk),
      .srst (1'b0),
      .arst (lrst_reg),
      .d    (vcr_reg),
      .q    (vcr_s)
   );

   assign sh_next    = {sh_reg[22:0], si};
   assign dummy_code = vcr_s[frvc_pkg::DUMMY_MSB:frvc_pkg::DUMMY_LSB];
   assign dummy_num  = (dummy_code == frvc_pkg::DUMMY_CODE_LO ||
                        dummy_code == frvc_pkg::DUMMY_CODE_HI) ?
                       frvc_pkg::DUMMY_DFLT : dummy_code;       // [R2] [R3]
   assign xip_en     = feat_xip || !vcr_s[frvc_pkg::XIP_BIT];   // [R7]
   assign byte_end   = (bit_cnt_reg == frvc_pkg::CNT_BYTE_LAST);
   assign req_fire   = (state_reg == frvc_pkg::LK_ADDR) &&
                       (bit_cnt_reg == frvc_pkg::CNT_ADDR_LAST);
   assign cfg_fire   = (state_reg == frvc_pkg::LK_WCFG) && byte_end;
   assign dummy_end  = (state_reg == frvc_pkg::LK_DUMMY) && (dcnt_reg == 4'h0);
   // An empty buffer means the dummy count was too short for the clock.
   assign pop_byte   = fifo_rvalid ? fifo_rdata : frvc_pkg::EMPTY_BYTE; // [R4]
   assign fifo_rready = dummy_end || ((state_reg == frvc_pkg::LK_DATA) &&
                        byte_end && !rd_cfg_reg);

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         state_reg   <= frvc_pkg::LK_START;
         bit_cnt_reg <= 5'h00;
         sh_reg      <= 24'h000000;
         dcnt_reg    <= 4'h0;
         dfirst_reg  <= 1'b0;
         out_sr_reg  <= 8'h00;
         rd_cfg_reg  <= 1'b0;
      end else begin
         sh_reg      <= sh_next;
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         unique case (state_reg)
            frvc_pkg::LK_START: begin
               state_reg <= xip_hold_reg ? frvc_pkg::LK_ADDR :
                                           frvc_pkg::LK_CMD;     // [R6]
            end
            frvc_pkg::LK_CMD: begin
               if (byte_end) begin
                  bit_cnt_reg <= 5'h00;
                  if (sh_next[7:0] == frvc_pkg::CMD_FAST_READ) begin
                     state_reg <= frvc_pkg::LK_ADDR;
                  end else if (sh_next[7:0] == frvc_pkg::CMD_WR_VCR) begin
                     state_reg <= frvc_pkg::LK_WCFG;
                  end else if (sh_next[7:0] == frvc_pkg::CMD_RD_VCR) begin
                     state_reg  <= frvc_pkg::LK_DATA;
                     rd_cfg_reg <= 1'b1;
                     out_sr_reg <= vcr_s;                        // [R13]
                  end else begin
                     state_reg <= frvc_pkg::LK_IGNORE;
                  end
               end
            end
            frvc_pkg::LK_ADDR: begin
               if (req_fire) begin
                  state_reg  <= frvc_pkg::LK_DUMMY;
                  dcnt_reg   <= dummy_num - 4'h1;                // [R1]
                  dfirst_reg <= 1'b1;
               end
            end
            frvc_pkg::LK_DUMMY: begin
               dfirst_reg <= 1'b0;
               dcnt_reg   <= dcnt_reg - 4'h1;
               if (dummy_end) begin
                  state_reg   <= frvc_pkg::LK_DATA;
                  bit_cnt_reg <= 5'h00;
                  out_sr_reg  <= pop_byte;                       // [R1]
               end
            end
            frvc_pkg::LK_DATA: begin
               if (byte_end) begin
                  bit_cnt_reg <= 5'h00;
                  out_sr_reg  <= rd_cfg_reg ? vcr_s : pop_byte;
               end else begin
                  out_sr_reg <= {out_sr_reg[6:0], 1'b0};
               end
            end
            frvc_pkg::LK_WCFG: begin
               if (byte_end) begin
                  state_reg <= frvc_pkg::LK_IGNORE;
               end
            end
            frvc_pkg::LK_IGNORE: begin
               bit_cnt_reg <= 5'h00;
            end
            default: begin
               state_reg <= frvc_pkg::LK_IGNORE;
            end
         endcase
      end
   end

   // Words handed to the core stay still until the next toggle.
   always_ff @(posedge sclk or posedge lrst_reg) begin
      if (lrst_reg) begin
         req_tog_reg   <= 1'b0;
         cfg_tog_reg   <= 1'b0;
         req_addr_reg  <= 24'h000000;
         cfg_wdata_reg <= frvc_pkg::VCR_RESET;
         xip_hold_reg  <= 1'b0;                                  // [R15]
      end else begin
         if (req_fire) begin
            req_tog_reg  <= !req_tog_reg;
            req_addr_reg <= sh_next;
         end
         if (cfg_fire) begin
            cfg_tog_reg   <= !cfg_tog_reg;
            cfg_wdata_reg <= sh_next[7:0];                       // [R13]
         end
         if (state_reg == frvc_pkg::LK_DUMMY && dfirst_reg) begin
            xip_hold_reg <= xip_en && !si;                       // [R6] [R7]
         end
      end
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so    <= out_sr_reg[7];
         so_oe <= (state_reg == frvc_pkg::LK_DATA);
      end
   end

endmodule : frvc_top

`default_nettype wire

// File: test/frvc_checker.sv
// Assertion checker for the read configuration block.
`timescale 1ns/100ps
`default_nettype none
module frvc_checker #(
   parameter logic [3:0] FEATURE_DIGIT = 4'h1
) (
   // Core clock and reset
   input wire logic       core_clk,
   input wire logic       srst,
   // Serial link
   input wire logic       cs_n,
   input wire logic       so,
   input wire logic       so_oe,
   // Straps and status
   input wire logic       nv_dual_n,
   input wire logic       nv_quad_n,
   input wire logic       xip_active,
   input wire logic [1:0] io_protocol,
   input wire logic [7:0] cfg_value
);
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   logic [3:0] up_cnt;
   logic [3:0] idle_cnt;
   logic       feat_xip;
   logic [1:0] proto_exp;
   assign feat_xip = (FEATURE_DIGIT == frvc_pkg::FEAT_XIP_A) ||
                     (FEATURE_DIGIT == frvc_pkg::FEAT_XIP_B);
   assign proto_exp = !nv_quad_n ? frvc_pkg::PROTO_QUAD :
                      !nv_dual_n ? frvc_pkg::PROTO_DUAL : frvc_pkg::PROTO_EXT;
   // Saturating, so long runs never wrap back into the antecedents.
   always_ff @(posedge core_clk) begin
      up_cnt   <= srst ? 4'h0 : up_cnt + {3'h0, up_cnt != 4'hf};
      idle_cnt <= (srst || !cs_n) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hf};
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   a_reserved_zero: assert property (cfg_value[2] == 1'b0)
      else $error("reserved bit reads one");
   a_reset_value: assert property (disable iff (1'b0)
      srst [*3] |-> cfg_value == frvc_pkg::VCR_RESET && !xip_active)
      else $error("reset value wrong");
   a_xip_mode: assert property (( up_cnt > 4'h3 &&
      $stable(cfg_value)) [*3] |-> xip_active == (feat_xip || !cfg_value[3]))
      else $error("execute in place mode wrong");
   a_proto_caught: assert property (up_cnt == 4'h5 |->
      io_protocol == proto_exp) else $error("protocol select wrong");
   a_proto_held: assert property (up_cnt > 4'h5 |->
      $stable(io_protocol)) else $error("protocol changed without reset");
   a_idle_quiet: assert property (cs_n [*2] |-> !so_oe && !so)
      else $error("output driven while deselected");
   a_oe_to_cs: assert property ($fell(so_oe) |-> cs_n)
      else $error("output enable dropped in frame");
   a_cfg_idle: assert property (idle_cnt == 4'hf |->
      $stable(cfg_value)) else $error("config changed without command");
endmodule : frvc_checker
bind frvc_top frvc_checker #(.FEATURE_DIGIT(FEATURE_DIGIT)) chk (
   .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .so(so),
   .so_oe(so_oe), .nv_dual_n(nv_dual_n), .nv_quad_n(nv_quad_n),
   .xip_active(xip_active), .io_protocol(io_protocol),
   .cfg_value(cfg_value));
`default_nettype wire

// File: test/frvc_host_model.sv
// Serial bus host model that frames commands on the link.
`timescale 1ns/100ps
`default_nettype none
module frvc_host_model (
   // Serial link
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic si,
   input  wire logic so
);
   // An 8 MHz link stays under every documented clock limit.
   localparam realtime HALF = 62.5;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   task automatic open_frame();
      #13;
      cs_n = 1'b0;
      #HALF;
   endtask : open_frame
   // Shifts n bits MSB first; so is taken at each rising edge.
   task automatic shift(input int n, input logic [31:0] out,
                        output logic [31:0] got);
      got = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         si = out[i];
         #HALF;
         sclk = 1'b1;
         got = {got[30:0], so};
         #HALF;
         sclk = 1'b0;
      end
   endtask : shift
   task automatic close_frame();
      #HALF;
      cs_n = 1'b1;
      // The data line has no pull, so show it changing once released.
      si = ~si;
   endtask : close_frame
endmodule : frvc_host_model
`default_nettype wire

// File: test/frvc_top_tb.sv
// Self-checking testbench for the read configuration block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module frvc_top_tb;
   logic       core_clk, srst, sclk, cs_n, si, so, so_oe, xip_active;
   logic       nv_dual_n, nv_quad_n, mem_we, xip_f2;
   logic [7:0] mem_addr, mem_wdata, cfg_value;
   logic [1:0] io_protocol, pe;
   logic [3:0] code;
   int         n_errors, compares, nd, ws;
   logic [7:0] cfgs [5] = '{8'h0c, 8'h3d, 8'he6, 8'h5b, 8'hf1};
   logic [7:0] starts [5] = '{8'h3f, 8'h0f, 8'h3f, 8'h01, 8'h1f};
   logic [1:0] pexp [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
   frvc_top dut (.core_clk(core_clk), .srst(srst), .sclk(sclk),
      .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .nv_dual_n(nv_dual_n), .nv_quad_n(nv_quad_n), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .xip_active(xip_active), .io_protocol(io_protocol),
      .cfg_value(cfg_value));
   frvc_top #(.FEATURE_DIGIT(4'h2)) dut_f2 (.core_clk(core_clk),
      .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(), .so_oe(),
      .nv_dual_n(nv_dual_n), .nv_quad_n(nv_quad_n), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .xip_active(xip_f2),
      .io_protocol(), .cfg_value());
   frvc_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic do_reset();
      srst = 1'b1;
      cyc(16);
      srst = 1'b0;
      cyc(6);
   endtask : do_reset
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic rd_cfg(input logic [7:0] e);
      logic [31:0] g;
      host.open_frame();
      host.shift(8, {24'h0, frvc_pkg::CMD_RD_VCR}, g);
      host.shift(16, 32'hffff_ffff, g);
      host.close_frame();
      `CHK(g[15:0], {e, e})
      cyc(4);
   endtask : rd_cfg
   // Waits a bounded time for the core copy, then reads the value back.
   task automatic wr_cfg(input logic [7:0] v);
      logic [31:0] g;
      int          k;
      host.open_frame();
      host.shift(16, {16'h0, frvc_pkg::CMD_WR_VCR, v}, g);
      host.close_frame();
      k = 0;
      while (cfg_value !== (v & 8'hfb) && k < 60) begin
         cyc(1);
         k++;
      end
      `CHK(cfg_value, v & 8'hfb)
      if (k == 60) tally_and_finish();
      rd_cfg(v & 8'hfb);
   endtask : wr_cfg
   // A set hold skips the command; keep sends a first dummy bit of zero.
   task automatic rd_data(input logic [7:0] a, input int n, input int st,
                          input logic hold, input logic keep);
      logic [31:0] g;
      logic [7:0]  b;
      logic [7:0]  m;
      b = a;
      m = 8'(st - 1);
      host.open_frame();
      if (!hold) host.shift(8, {24'h0, frvc_pkg::CMD_FAST_READ}, g);
      host.shift(24, {24'h0, a}, g);
      host.shift(1, {31'h0, !keep}, g);
      host.shift(n - 1, 32'hffff_ffff, g);
      for (int i = 0; i < 18; i++) begin
         host.shift(8, 32'hffff_ffff, g);
         `CHK(g[7:0], b ^ 8'h5a)
         b = (b & ~m) | ((b + 8'h01) & m);
      end
      host.close_frame();
      cyc(4);
   endtask : rd_data
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {srst, mem_we, nv_dual_n, nv_quad_n} = 4'h3;
      {mem_addr, mem_wdata} = 16'h0;
      n_errors = 0;
      compares = 0;
      do_reset();
      `CHK(cfg_value, 8'hfb)
      `CHK(xip_active, 1'b0)
      `CHK(xip_f2, 1'b1)
      rd_cfg(8'hfb);
      for (int i = 0; i < 256; i++) begin
         mem_we    = 1'b1;
         mem_addr  = 8'(i);
         mem_wdata = 8'(i) ^ 8'h5a;
         cyc(1);
      end
      mem_we = 1'b0;
      rd_data(8'hf8, 10, 256, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr_cfg(cfgs[i]);
         cyc(4);
         `CHK(xip_active, ~cfgs[i][3])
         `CHK(xip_f2, 1'b1)
         code = cfgs[i][7:4];
         nd = (code == 4'h0 || code == 4'hf) ? 10 : int'(code);
         ws = (cfgs[i][1:0] == 2'h3) ? 256 : 16 << cfgs[i][1:0];
         rd_data(starts[i], nd, ws, 1'b0, !cfgs[i][3]);
         // With the mode enabled the next frame carries no command byte.
         if (!cfgs[i][3]) begin
            rd_data(starts[i] + 8'h05, nd, ws, 1'b1, 1'b0);
         end
      end
      pe = 2'h0;
      for (int s = 0; s < 4; s++) begin
         {nv_quad_n, nv_dual_n} = 2'(s);
         cyc(8);
         `CHK(io_protocol, pe)
         do_reset();
         pe = pexp[s];
         `CHK(io_protocol, pe)
         `CHK(cfg_value, 8'hfb)
      end
      tally_and_finish();
   end
endmodule : frvc_top_tb
`default_nettype wire
